// ==== rtl/phy_mode_rate_select.sv ====
// PHY mode selection: register file, resolved mode, symbol tick, frame phase,
// acknowledgement and energy detection timers, and sync gating.
// Assumes one 10 MHz clock, a Wishbone classic master and a baseband that
// reports symbol boundaries and RSSI on the same clock.
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "phy_mode_regs.svh"

// Operation
// [R1] BPSK spreads at 300 or 600 kchip/s
// [R2] BPSK shaping is raised cosine 1.0
// [R3] O-QPSK chip rate 400 or 1000 kchip/s
// [R4] Low O-QPSK rate: half-sine plus RC-0.2
// [R5] High O-QPSK rate: half-sine or RC-0.8
// [R6] Base O-QPSK gives 100 or 250 kbit/s
// [R7] High rates shorten spreading by 2 or 4
// [R8] High rate spreading covers payload only
// [R9] Host changes mode only while radio idle
// [R10] Symbol period 50, 25, 40, 16 us
// [R11] High rate modes use base symbol period
// [R12] Ack time 2/3 short, else 12 symbols
// [R13] No sync below sensitivity threshold
// [R14] Scramble at 400/1000 unless disabled
// [R15] Automatic ED lasts 2 symbols at high rate
// [R16] Manual ED always lasts 8 symbols
// [R17] No carrier sense CCA at high rate
// [R18] Host discards LQI at high rate
// [R19] Modulation bit: 0 BPSK, 1 O-QPSK
// [R20] Chip bit selects higher or lower chip rate
// [R21] Rate field: base, double, quadruple; 3 reserved
// [R22] High chip rate shaping chosen by RC bit
// [R23] Spreading switches at first payload chip
module phy_mode_rate_select
    import phy_mode_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic frame_start_i,
    input wire logic symbol_done_i,
    input wire logic frame_end_i,
    input wire logic [7:0] rssi_i,
    input wire logic sync_detect_i,
    input wire logic ack_start_i,
    input wire logic ed_auto_start_i,
    input wire logic ed_manual_start_i,
    output phy_cfg_s phy_cfg_o,
    output logic [1:0] active_spread_div_o,
    output logic symbol_tick_o,
    output logic sync_accept_o,
    output logic ack_due_o,
    output logic ed_busy_o,
    output logic ed_done_o
);

    // ------------------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------------------
    // Symbol periods in clock cycles; all are whole at 10 MHz.
    localparam logic [15:0] CYC_BPSK20 = 16'(`SYM_CYC(`SYM_NS_BPSK20));
    localparam logic [15:0] CYC_BPSK40 = 16'(`SYM_CYC(`SYM_NS_BPSK40));
    localparam logic [15:0] CYC_OQ400 = 16'(`SYM_CYC(`SYM_NS_OQ400));
    localparam logic [15:0] CYC_OQ1000 = 16'(`SYM_CYC(`SYM_NS_OQ1000));

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [7:0] phy_mode_control_reg; // Mode bits.
    logic [7:0] extended_mode_control_reg; // Holds short acknowledgement bit.
    logic [7:0] receive_sync_threshold_reg; // Zero disables the threshold.
    logic radio_idle_state_reg; // Software sets while the radio is off.
    logic mode_write_blocked_reg; // Sticky: mode write tried while busy.
    phase_e phase_reg; // Frame phase.
    logic [15:0] sym_cnt_reg; // Symbol period divider.
    logic [4:0] hdr_cnt_reg; // Header symbols seen.
    logic [4:0] ack_cnt_reg; // Ack symbols remaining.
    logic ack_run_reg; // Ack timer active.
    logic [3:0] ed_cnt_reg; // ED symbols remaining.

    // Wishbone request decode.
    logic req;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // ------------------------------------------------------------------------
    // Mode resolution
    // ------------------------------------------------------------------------
    logic mod_oq; // [R19]
    logic chip_hi; // [R20]
    logic [1:0] rate_sel;
    logic high_rate;
    logic [15:0] sym_period;
    assign mod_oq = phy_mode_control_reg[`FLD_MOD_SEL];
    assign chip_hi = phy_mode_control_reg[`FLD_CHIP_SEL];
    // Reserved rate value 3 falls back to the base rate so the link stays sane.
    assign rate_sel = (phy_mode_control_reg[1:0] == 2'h3) ? 2'h0 : phy_mode_control_reg[1:0]; // [R21]
    assign high_rate = mod_oq && (rate_sel != 2'h0); // [R7]

    // Symbol period depends only on modulation and chip rate, never on the
    // payload rate, so high rate modes time with their base period.
    always_comb begin
        if (!mod_oq) begin
            sym_period = chip_hi ? CYC_BPSK40 : CYC_BPSK20; // [R1] [R10]
        end else begin
            sym_period = chip_hi ? CYC_OQ1000 : CYC_OQ400; // [R3] [R10] [R11]
        end
    end

    // ------------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------------
    // Mode writes are only honoured in the idle state; a write while busy is
    // dropped and flagged rather than corrupting a frame in flight.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            phy_mode_control_reg <= `PHY_MODE_CONTROL_RST;
            extended_mode_control_reg <= `EXT_MODE_CONTROL_RST;
            receive_sync_threshold_reg <= `RX_SYNC_THRESH_RST;
            radio_idle_state_reg <= 1'b1;
            mode_write_blocked_reg <= 1'b0;
        end else if (req && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
                `PHY_MODE_CONTROL_OFS: begin
                    if (radio_idle_state_reg) begin
                        phy_mode_control_reg <= wb_dat_i[7:0]; // [R9]
                    end else begin
                        mode_write_blocked_reg <= 1'b1;
                    end
                end
                `EXT_MODE_CONTROL_OFS: begin
                    extended_mode_control_reg <= wb_dat_i[7:0];
                end
                `RX_SYNC_THRESH_OFS: begin
                    receive_sync_threshold_reg <= wb_dat_i[7:0];
                end
                `PHY_STATUS_OFS: begin
                    // Writing one clears the blocked flag.
                    if (wb_dat_i[0]) begin
                        mode_write_blocked_reg <= 1'b0;
                    end
                end
                `RADIO_CONTROL_OFS: begin
                    radio_idle_state_reg <= wb_dat_i[0];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Wishbone answer
    // ------------------------------------------------------------------------
    // Ack one cycle after the request; unmapped addresses read zero.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= 32'h0000_0000;
            if (req && !wb_we_i) begin
                case (wb_adr_i)
                    `PHY_MODE_CONTROL_OFS: wb_dat_o <= {24'h00_0000, phy_mode_control_reg};
                    `EXT_MODE_CONTROL_OFS: wb_dat_o <= {24'h00_0000, extended_mode_control_reg};
                    `RX_SYNC_THRESH_OFS: wb_dat_o <= {24'h00_0000, receive_sync_threshold_reg};
                    `PHY_STATUS_OFS: wb_dat_o <= {26'h000_0000, phase_reg, ed_busy_o,
                        ack_run_reg, mode_write_blocked_reg};
                    `RADIO_CONTROL_OFS: wb_dat_o <= {31'h0000_0000, radio_idle_state_reg};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Resolved configuration
    // ------------------------------------------------------------------------
    // Registered copy of the mode so the baseband sees clean levels.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            phy_cfg_o <= '0;
        end else begin
            phy_cfg_o.modulation <= mod_oq ? MOD_OQPSK : MOD_BPSK; // [R19]
            phy_cfg_o.high_chip <= chip_hi; // [R20]
            phy_cfg_o.spread_div <= mod_oq ? rate_sel : 2'h0; // [R6] [R7]
            // Scrambler only at quadruple rate, default on.
            phy_cfg_o.scramble <= mod_oq && (rate_sel == 2'h2)
                && phy_mode_control_reg[`FLD_SCRAM]; // [R14]
            if (!mod_oq) begin
                phy_cfg_o.shaping <= SHAPE_RC10; // [R2]
            end else if (!chip_hi) begin
                phy_cfg_o.shaping <= SHAPE_SIN_RC02; // [R4]
            end else begin
                phy_cfg_o.shaping <= phy_mode_control_reg[`FLD_RC_EN]
                    ? SHAPE_RC08 : SHAPE_SIN; // [R5] [R22]
            end
            phy_cfg_o.high_rate <= high_rate;
            phy_cfg_o.carrier_sense_ok <= !high_rate; // [R17]
        end
    end

    // ------------------------------------------------------------------------
    // Symbol tick divider
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sym_cnt_reg <= 16'h0000;
            symbol_tick_o <= 1'b0;
        end else if (sym_cnt_reg >= sym_period - 16'h0001) begin
            sym_cnt_reg <= 16'h0000;
            symbol_tick_o <= 1'b1; // [R10] [R11]
        end else begin
            sym_cnt_reg <= sym_cnt_reg + 16'h0001;
            symbol_tick_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Frame phase: header at base rate, payload at selected rate
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            phase_reg <= PH_IDLE;
            hdr_cnt_reg <= 5'h00;
        end else if (frame_end_i) begin
            phase_reg <= PH_IDLE;
        end else begin
            case (phase_reg)
                PH_IDLE: begin
                    if (frame_start_i) begin
                        phase_reg <= PH_HEADER;
                        hdr_cnt_reg <= 5'h00;
                    end
                end
                PH_HEADER: begin
                    if (symbol_done_i) begin
                        if (hdr_cnt_reg == 5'(`HDR_SYMBOLS - 1)) begin
                            phase_reg <= PH_PAYLOAD; // [R23]
                        end
                        hdr_cnt_reg <= hdr_cnt_reg + 5'h01;
                    end
                end
                PH_PAYLOAD: begin
                end
                default: phase_reg <= PH_IDLE;
            endcase
        end
    end

    // Spreading in use right now: base rate outside the payload.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            active_spread_div_o <= 2'h0;
        end else begin
            active_spread_div_o <= (phase_reg == PH_PAYLOAD && mod_oq) ? rate_sel : 2'h0; // [R8]
        end
    end

    // ------------------------------------------------------------------------
    // Sync gating
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sync_accept_o <= 1'b0;
        end else begin
            sync_accept_o <= sync_detect_i && (receive_sync_threshold_reg == 8'h00
                || rssi_i >= receive_sync_threshold_reg); // [R13]
        end
    end

    // ------------------------------------------------------------------------
    // Acknowledgement timer
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ack_run_reg <= 1'b0;
            ack_cnt_reg <= 5'h00;
            ack_due_o <= 1'b0;
        end else begin
            ack_due_o <= 1'b0;
            if (ack_start_i) begin
                ack_run_reg <= 1'b1;
                if (extended_mode_control_reg[`FLD_SHORT_ACK] && high_rate) begin
                    ack_cnt_reg <= chip_hi ? 5'(`ACK_SHORT_HIGH_SYM)
                        : 5'(`ACK_SHORT_LOW_SYM); // [R12]
                end else begin
                    ack_cnt_reg <= 5'(`ACK_LONG_SYM); // [R12]
                end
            end else if (ack_run_reg && symbol_tick_o) begin
                if (ack_cnt_reg == 5'h01) begin
                    ack_run_reg <= 1'b0;
                    ack_due_o <= 1'b1;
                end
                ack_cnt_reg <= ack_cnt_reg - 5'h01;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Energy detection timer
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ed_busy_o <= 1'b0;
            ed_cnt_reg <= 4'h0;
            ed_done_o <= 1'b0;
        end else begin
            ed_done_o <= 1'b0;
            if (ed_manual_start_i) begin
                ed_busy_o <= 1'b1;
                ed_cnt_reg <= 4'(`ED_NORMAL_SYM); // [R16]
            end else if (ed_auto_start_i) begin
                ed_busy_o <= 1'b1;
                ed_cnt_reg <= high_rate ? 4'(`ED_SHORT_SYM) : 4'(`ED_NORMAL_SYM); // [R15]
            end else if (ed_busy_o && symbol_tick_o) begin
                if (ed_cnt_reg == 4'h1) begin
                    ed_busy_o <= 1'b0;
                    ed_done_o <= 1'b1;
                end
                ed_cnt_reg <= ed_cnt_reg - 4'h1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    scram_only_quad_a: assert property (phy_cfg_o.scramble |-> phy_cfg_o.spread_div == 2'h2) // [R14]
        else $error("scrambler on outside quadruple rate");
    cs_high_rate_a: assert property (phy_cfg_o.high_rate |-> !phy_cfg_o.carrier_sense_ok) // [R17]
        else $error("carrier sense offered at high rate");
    bpsk_shape_a: assert property (phy_cfg_o.modulation == MOD_BPSK
        |-> phy_cfg_o.shaping == SHAPE_RC10) // [R2]
        else $error("wrong BPSK shaping");
    header_base_a: assert property (phase_reg != PH_PAYLOAD |=> active_spread_div_o == 2'h0) // [R8]
        else $error("header spread at high rate");
    busy_mode_hold_a: assert property (!radio_idle_state_reg |=> $stable(phy_mode_control_reg)) // [R9]
        else $error("mode changed while busy");
    sync_gate_a: assert property (sync_accept_o |-> $past(sync_detect_i)) // [R13]
        else $error("sync accepted without detect");
    manual_ed_a: assert property (ed_manual_start_i |=> ed_cnt_reg == 4'h8) // [R16]
        else $error("manual ED not eight symbols");
    ack_long_a: assert property (ack_start_i && !extended_mode_control_reg[`FLD_SHORT_ACK]
        |=> ack_cnt_reg == 5'h0c) // [R12]
        else $error("long ack count wrong");
    wb_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus not answered in one cycle");

    payload_c: cover property (phase_reg == PH_HEADER ##1 phase_reg == PH_PAYLOAD);
    ack_short_c: cover property (ack_due_o && extended_mode_control_reg[`FLD_SHORT_ACK]);
    ed_auto_c: cover property (ed_auto_start_i && high_rate);
    blocked_c: cover property (mode_write_blocked_reg);

endmodule

// ==== rtl/phy_mode_regs.svh ====
// Register offsets, field positions, reset values and timing counts for the PHY mode block.
// Assumes a 10 MHz system clock and a 32-bit classic Wishbone slave port.
`ifndef PHY_MODE_REGS_SVH
`define PHY_MODE_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define PHY_MODE_CONTROL_OFS 8'h0c
`define EXT_MODE_CONTROL_OFS 8'h10
`define RX_SYNC_THRESH_OFS 8'h14
`define PHY_STATUS_OFS 8'h18
`define RADIO_CONTROL_OFS 8'h1c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define FLD_RX_SAFE 7
`define FLD_IDLE_AVDD 6
`define FLD_SCRAM 5
`define FLD_RC_EN 4
`define FLD_MOD_SEL 3
`define FLD_CHIP_SEL 2
`define FLD_SHORT_ACK 2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PHY_MODE_CONTROL_RST 8'h24
`define EXT_MODE_CONTROL_RST 8'h00
`define RX_SYNC_THRESH_RST 8'h00

// ----------------------------------------------------------------------------
// Timing: clock rate, symbol periods in ns and symbol counts
// ----------------------------------------------------------------------------
`define CLK_HZ 10000000
`define SYM_NS_BPSK20 50000
`define SYM_NS_BPSK40 25000
`define SYM_NS_OQ400 40000
`define SYM_NS_OQ1000 16000
`define SYM_CYC(ns) (((ns) * (`CLK_HZ / 1000000)) / 1000)
`define ACK_LONG_SYM 12
`define ACK_SHORT_LOW_SYM 2
`define ACK_SHORT_HIGH_SYM 3
`define ED_NORMAL_SYM 8
`define ED_SHORT_SYM 2
`define HDR_SYMBOLS 12

`endif

// ==== rtl/phy_mode_pkg.sv ====
// Types shared by the PHY mode selection block.
// Assumes the register header supplies all numeric constants.
package phy_mode_pkg;

    // Modulation choice.
    typedef enum logic {
        MOD_BPSK = 1'b0,
        MOD_OQPSK = 1'b1
    } modulation_e;

    // Pulse shaping in use.
    typedef enum logic [1:0] {
        SHAPE_RC10 = 2'h0,
        SHAPE_SIN_RC02 = 2'h1,
        SHAPE_SIN = 2'h2,
        SHAPE_RC08 = 2'h3
    } shaping_e;

    // Resolved PHY configuration carried to the baseband.
    typedef struct packed {
        modulation_e modulation;
        logic high_chip;
        logic [1:0] spread_div;
        logic scramble;
        shaping_e shaping;
        logic high_rate;
        logic carrier_sense_ok;
    } phy_cfg_s;

    // Frame phase states, one-hot.
    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_HEADER = 3'b010,
        PH_PAYLOAD = 3'b100
    } phase_e;

endpackage

// ==== tb/peer_radio_model.sv ====
// Peer radio model: frames header symbols and reports signal strength and sync.
// Assumes the shared clock; it launches every pulse right after a rising edge.
`timescale 1ns/1ps
module peer_radio_model (
    input wire logic clk_i,
    output logic frame_start_o,
    output logic symbol_done_o,
    output logic frame_end_o,
    output logic [7:0] rssi_o,
    output logic sync_detect_o
);
    // ------------------------------------------------------------------
    // Idle state
    // ------------------------------------------------------------------
    // Strobes idle low and the strength sits at the noise floor.
    initial begin
        frame_start_o = 1'b0;
        symbol_done_o = 1'b0;
        frame_end_o = 1'b0;
        sync_detect_o = 1'b0;
        rssi_o = 8'h00;
    end

    // Raise one strobe for exactly one cycle.
    task automatic pulse(input int which);
        @(posedge clk_i);
        case (which)
            0: frame_start_o <= 1'b1;
            1: symbol_done_o <= 1'b1;
            2: frame_end_o <= 1'b1;
            default: sync_detect_o <= 1'b1;
        endcase
        @(posedge clk_i);
        frame_start_o <= 1'b0;
        symbol_done_o <= 1'b0;
        frame_end_o <= 1'b0;
        sync_detect_o <= 1'b0;
    endtask

    // Start a frame and send n header symbols, one every five cycles, far faster than a real peer.
    task automatic header(input int n);
        pulse(0);
        for (int i = 0; i < n; i++) begin
            repeat (3) @(posedge clk_i);
            pulse(1);
        end
    endtask

    // Present a strength level, then report a detected sync word.
    task automatic sync_at(input logic [7:0] level);
        @(posedge clk_i);
        rssi_o <= level;
        pulse(3);
    endtask
endmodule

// ==== tb/phy_mode_rate_select_tb.sv ====
// Testbench for the PHY mode block: register bus, mode table, timers, header switch.
// Assumes the design package, the register header and the peer radio model.
`timescale 1ns/1ps
`include "phy_mode_regs.svh"
module phy_mode_rate_select_tb
    import phy_mode_pkg::*;
;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, rd, wb_dat_o;
    logic ack, fs, sd, fe, sy, tick, sacc, ack_due, ed_busy, ed_done, hit;
    logic ack_start = 1'b0, ed_auto = 1'b0, ed_man = 1'b0;
    logic [7:0] rssi;
    logic [1:0] act;
    phy_cfg_s cfg;
    int n_fail = 0, comparisons = 0, t;
    // Mode codes: every modulation, chip rate, rate code, shaping and scrambler case.
    logic [7:0] modes [16] = '{8'h00, 8'h04, 8'h08, 8'h09, 8'h2a, 8'h0a, 8'h0c, 8'h0d,
        8'h2e, 8'h0e, 8'h1c, 8'h1d, 8'h3e, 8'h1e, 8'h0b, 8'h1a};
    // Symbol period in cycles of 100 ns; high rate modes keep the base period.
    logic [7:0] pmode [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h2e, 8'h0a};
    int pcyc [6] = '{500, 250, 400, 160, 160, 400};

    always #50 clk_i = ~clk_i;

    phy_mode_rate_select u_dut (.clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(ack), .frame_start_i(fs), .symbol_done_i(sd),
        .frame_end_i(fe), .rssi_i(rssi), .sync_detect_i(sy), .ack_start_i(ack_start),
        .ed_auto_start_i(ed_auto), .ed_manual_start_i(ed_man), .phy_cfg_o(cfg),
        .active_spread_div_o(act), .symbol_tick_o(tick), .sync_accept_o(sacc),
        .ack_due_o(ack_due), .ed_busy_o(ed_busy), .ed_done_o(ed_done));

    peer_radio_model u_peer (.clk_i(clk_i), .frame_start_o(fs), .symbol_done_o(sd),
        .frame_end_o(fe), .rssi_o(rssi), .sync_detect_o(sy));

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // A bound that runs out is a mismatch and ends the run.
    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            n_fail++;
            results();
        end
    endtask

    // ------------------------------------------------------------------
    // Classic Wishbone master: hold the request until ack is sampled high.
    // ------------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        bound(n, 50);
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d}, 4'h1);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(rd, exp);
    endtask

    // Expected resolved configuration, worked out from the mode bits alone.
    function automatic phy_cfg_s want(input logic [7:0] v);
        phy_cfg_s c;
        logic [1:0] r;
        r = (v[3] && v[1:0] != 2'h3) ? v[1:0] : 2'h0;
        c.modulation = modulation_e'(v[3]);
        c.high_chip = v[2];
        c.spread_div = r;
        c.scramble = (r == 2'h2) && v[5];
        c.shaping = !v[3] ? SHAPE_RC10 : !v[2] ? SHAPE_SIN_RC02 : v[4] ? SHAPE_RC08 : SHAPE_SIN;
        c.high_rate = (r != 2'h0);
        c.carrier_sense_ok = (r == 2'h0);
        return c;
    endfunction

    // Cycles from one symbol tick to the next.
    task automatic period(output int p);
        int n;
        n = 0;
        while (tick !== 1'b1 && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        bound(n, 2000);
        p = 0;
        do begin
            @(posedge clk_i);
            p++;
        end while (tick !== 1'b1 && p < 2000);
        bound(p, 2000);
    endtask

    // Start a timer (0 ack, 1 automatic ED, 2 manual ED) and count ticks to its end.
    task automatic timer(input int which, output int k);
        int n;
        n = 0;
        k = 0;
        @(posedge clk_i);
        ack_start <= (which == 0);
        ed_auto <= (which == 1);
        ed_man <= (which == 2);
        @(posedge clk_i);
        ack_start <= 1'b0;
        ed_auto <= 1'b0;
        ed_man <= 1'b0;
        do begin
            @(posedge clk_i);
            n++;
            if (tick === 1'b1) k++;
            if (n == 1) chk(ed_busy, which != 0);
        end while ((which == 0 ? ack_due : ed_done) !== 1'b1 && n < 10000);
        bound(n, 10000);
        chk(ed_busy, 1'b0);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        rdc(8'h0c, 32'h24);
        rdc(8'h10, 32'h0);
        rdc(8'h14, 32'h0);
        rdc(8'h40, 32'h0);
        chk(cfg, want(8'h24));
        // The host writes the mode only while the radio is idle.
        foreach (modes[i]) begin
            wr(8'h0c, modes[i]);
            rdc(8'h0c, {24'h0, modes[i]});
            chk(cfg, want(modes[i]));
        end
        foreach (pmode[i]) begin
            wr(8'h0c, pmode[i]);
            period(t);
            period(t);
            chk(t, pcyc[i]);
        end
        wr(8'h10, 8'h04);
        wr(8'h0c, 8'h0e);
        timer(0, t);
        chk(t, 3);
        timer(1, t);
        chk(t, 2);
        timer(2, t);
        chk(t, 8);
        wr(8'h0c, 8'h0a);
        timer(0, t);
        chk(t, 2);
        wr(8'h10, 8'h00);
        timer(0, t);
        chk(t, 12);
        wr(8'h0c, 8'h08);
        timer(1, t);
        chk(t, 8);
        // Below, at and without a threshold.
        for (int i = 0; i < 3; i++) begin
            wr(8'h14, (i == 2) ? 8'h00 : 8'h40);
            u_peer.sync_at((i == 0) ? 8'h3f : 8'h40);
            hit = 1'b0;
            repeat (5) @(posedge clk_i) if (sacc === 1'b1) hit = 1'b1;
            chk(hit, i != 0);
        end
        // Header at base rate, payload at the doubled rate.
        wr(8'h0c, 8'h0d);
        u_peer.header(11);
        repeat (3) @(posedge clk_i);
        chk(act, 2'h0);
        u_peer.pulse(1);
        repeat (3) @(posedge clk_i);
        chk(act, 2'h1);
        u_peer.pulse(2);
        repeat (3) @(posedge clk_i);
        chk(act, 2'h0);
        // Mode writes while the radio is busy or without a byte lane are refused.
        wr(8'h1c, 8'h00);
        wr(8'h0c, 8'h08);
        rdc(8'h0c, 32'h0d);
        bus(1'b0, 8'h18, 32'h0, 4'hf);
        chk(rd[0], 1'b1);
        wr(8'h18, 8'h01);
        bus(1'b0, 8'h18, 32'h0, 4'hf);
        chk(rd[0], 1'b0);
        wr(8'h1c, 8'h01);
        bus(1'b1, 8'h0c, 32'h08, 4'h0);
        rdc(8'h0c, 32'h0d);
        results();
    end
endmodule
